// ===== inc/temp_regs_pkg.sv
package temp_regs_pkg;

  // ------------------------------------------------------------
  // register addresses (3-bit field of the command byte)
  // ------------------------------------------------------------
  localparam logic [2:0] ADDR_STATUS = 3'h0;
  localparam logic [2:0] ADDR_CONFIG = 3'h1;
  localparam logic [2:0] ADDR_TEMP   = 3'h2;
  localparam logic [2:0] ADDR_IDENT  = 3'h3;
  localparam logic [2:0] ADDR_CRIT   = 3'h4;
  localparam logic [2:0] ADDR_HYST   = 3'h5;
  localparam logic [2:0] ADDR_HIGH   = 3'h6;
  localparam logic [2:0] ADDR_LOW    = 3'h7;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [15:0] TEMP_RST   = 16'h0000;
  localparam logic [7:0]  CONFIG_RST = 8'h00;
  localparam logic [15:0] CRIT_RST   = 16'h4980;
  localparam logic [7:0]  HYST_RST   = 8'h05;
  localparam logic [15:0] HIGH_RST   = 16'h2000;
  localparam logic [15:0] LOW_RST    = 16'h0500;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CFG_QUEUE_LSB = 0;  // fault queue code [1:0]
  localparam int CFG_CT_POL    = 2;  // critical pin polarity
  localparam int CFG_INT_POL   = 3;  // limit pin polarity
  localparam int CFG_CMP_MODE  = 4;  // 1 = comparator, 0 = interrupt
  localparam int CFG_OP_LSB    = 5;  // operation mode [6:5]
  localparam int CFG_RES16     = 7;  // 1 = 16-bit result
  localparam logic [1:0] OP_SHUTDOWN = 2'h3;
  localparam int FLAG_BITS     = 3;  // result bits used as flags
  localparam int HYST_BITS     = 4;  // used bits of hysteresis
  localparam int HYST_SHIFT    = 7;  // one degree = 128 lsb
  localparam int STAT_FLAG_LSB = 4;  // status flags [6:4]
  localparam int STAT_RDY      = 7;

  // limit index: also the flag position in the result word
  localparam int LIM_LOW  = 0;
  localparam int LIM_HIGH = 1;
  localparam int LIM_CRIT = 2;

endpackage

// ===== core/limit_check.sv
`timescale 1ns/1ps
`default_nettype none

module limit_check (
  input  wire logic signed [15:0] temp,     // compared temperature
  input  wire logic signed [15:0] limit,    // limit word
  input  wire logic [3:0]         hyst,     // hysteresis, whole degrees
  input  wire logic               upper,    // 1 = over limit, 0 = under
  output logic                    beyond,   // past the limit
  output logic                    released  // back past the hysteresis point
);

  logic signed [16:0] thr;
  logic signed [16:0] hyst_w;
  logic signed [16:0] t17;

  // ------------------------------------------------------------
  // threshold arithmetic in 17 bits so no limit can wrap
  // ------------------------------------------------------------
  always_comb
  begin
    hyst_w = 17'(signed'({1'b0, hyst, 7'h00}));
    t17    = 17'(temp);
    thr    = upper ? 17'(limit) - hyst_w : 17'(limit) + hyst_w;
    beyond = upper ? (temp > limit) : (temp < limit);
    released = upper ? (t17 < thr) : (t17 > thr);
  end

endmodule // limit_check

`default_nettype wire

// ===== core/fault_queue.sv
`timescale 1ns/1ps
`default_nettype none

module fault_queue #(
  parameter int W = 2                 // width of the queue code
) (
  input  wire logic         clk,      // system clock
  input  wire logic         rst_n,    // synchronised reset, active low
  input  wire logic         sample,   // one conversion result arrives
  input  wire logic         fault,    // this result is past the limit
  input  wire logic [W-1:0] need,     // code: faults needed minus one
  output logic              trip      // queue full on this sample
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } q_state_t;

  q_state_t s_reg;
  q_state_t s_next;

  // refused at elaboration: the counter must be one to eight bits
  if (W < 1 || W > 8)
  begin : g_bad_w
    $error("fault_queue: W out of range");
  end

  // ------------------------------------------------------------
  // count earlier consecutive faults, saturating at the top code
  // ------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    trip   = sample && fault && (s_reg.cnt >= need);
    if (sample)
    begin
      if (!fault)
        s_next.cnt = '0;
      else if (s_reg.cnt != {W{1'b1}})
        s_next.cnt = s_reg.cnt + W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

endmodule // fault_queue

`default_nettype wire

// ===== core/temp_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - result register at 0x02, signed 16 bits
// - 13-bit mode: low bits flag crit/high/low
// - 16-bit mode: low bits extend the value
// - sign bit 15, value below, resets zero
// - identity register at 0x03, maker and revision
// - critical limit at 0x04 drives critical output
// - critical limit read/write, resets to 0x4980
// - hysteresis at 0x05, four low bits used
// - release points: limit minus/plus hysteresis
// - hysteresis resets to five degrees
// - high limit at 0x06 raises limit alarm
// - high limit read/write, resets to 0x2000
// - low limit at 0x07 raises limit alarm
// - low limit read/write, resets to 0x0500
// - configuration bit 7 selects 13/16-bit result
// - fault queue: one to four consecutive faults
// - comparator mode clears past hysteresis point
// - interrupt mode clears on any register read

module temp_regs #(
  parameter logic [4:0] MAKER_CODE = 5'h0A,  // arbitrary value
  parameter logic [2:0] REV_CODE   = 3'h1,   // arbitrary value
  parameter int         QUEUE_W    = 2       // fault queue code width
) (
  input  wire logic        clk,                    // 10 MHz clock
  input  wire logic        rst_n,                  // async reset, active low
  input  wire logic        reg_wr,                 // register write strobe
  input  wire logic        reg_rd,                 // register read strobe
  input  wire logic [2:0]  reg_addr,               // register address
  input  wire logic [15:0] reg_wdata,              // write data
  input  wire logic        conv_valid,             // new conversion result
  input  wire logic [15:0] conv_data,              // converter result word
  output logic [15:0]      reg_rdata,              // read data
  output logic             reg_rvalid,             // read data valid
  output logic             critical_alarm_output,  // critical pin level
  output logic             limit_alarm_output      // limit alarm pin level
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  // every register, flag and pin level but the fault queue counts lives
  // in one word so that one process decides that next state; this keeps the order
  // of clears and sets in a single place where it can be read
  typedef struct packed {
    logic [15:0] temp;
    logic [7:0]  cfg;
    logic [15:0] crit;
    logic [7:0]  hyst;
    logic [15:0] high;
    logic [15:0] low;
    logic [2:0]  flags;     // status flags per limit, cleared on status read or release
    logic        rdy;       // high while no unread result
    logic [2:0]  excur;     // temperature is in an excursion
    logic [2:0]  alarm;     // alarm state per limit
    logic        crit_pin;
    logic        limit_pin;
    logic [15:0] rdata;
    logic        rvalid;
  } regs_state_t;

  regs_state_t s_reg;
  regs_state_t s_next;

  logic [1:0]        rst_sync;
  logic              rst_int_n;
  logic signed [15:0] cmp_temp;
  logic [2:0]        beyond;
  logic [2:0]        released;
  logic [2:0]        trip;
  logic              res16;
  logic              cmp_mode;
  logic              shutdown;
  logic [QUEUE_W-1:0] need;

  // refused at elaboration: a one-bit code cannot count four faults
  if (QUEUE_W < 2)
  begin : g_bad_queue_w
    $error("temp_regs: QUEUE_W must hold four fault counts");
  end

  // ------------------------------------------------------------
  // reset release through two flops
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end

  assign rst_int_n = rst_sync[1];

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // limit word for a given limit index
  function automatic logic [15:0] lim_of(input int idx, input regs_state_t s);
    begin
      unique case (idx)
        temp_regs_pkg::LIM_LOW:  lim_of = s.low;
        temp_regs_pkg::LIM_HIGH: lim_of = s.high;
        default:                 lim_of = s.crit;
      endcase
    end
  endfunction

  // pin level from alarm state and polarity bit (0 = active low)
  function automatic logic pin_level(input logic act, input logic pol);
    begin
      pin_level = act ? pol : ~pol;
    end
  endfunction

  // ------------------------------------------------------------
  // configuration decode
  // ------------------------------------------------------------
  assign res16    = s_reg.cfg[temp_regs_pkg::CFG_RES16];
  assign cmp_mode = s_reg.cfg[temp_regs_pkg::CFG_CMP_MODE];
  assign shutdown = s_reg.cfg[temp_regs_pkg::CFG_OP_LSB +: 2]
                    == temp_regs_pkg::OP_SHUTDOWN;
  assign need     = QUEUE_W'(s_reg.cfg[temp_regs_pkg::CFG_QUEUE_LSB +: 2]);

  // compare the value being stored; in 13-bit mode the flag
  // positions are not temperature and must not move the compare
  assign cmp_temp = res16 ? conv_data
                  : {conv_data[15:3], 3'h0};

  // ------------------------------------------------------------
  // one compare and one fault queue per limit
  // ------------------------------------------------------------
  // the loop index doubles as the flag position in the result word,
  // so the low limit lands in bit 0 and the critical limit in bit 2;
  // the queues see the raw compare, the alarms only see their trips
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_lim
      limit_check u_chk (
        .temp     (cmp_temp),
        .limit    (lim_of(gi, s_reg)),
        .hyst     (s_reg.hyst[temp_regs_pkg::HYST_BITS-1:0]),
        .upper    (gi != temp_regs_pkg::LIM_LOW),
        .beyond   (beyond[gi]),
        .released (released[gi])
      );

      fault_queue #(
        .W (QUEUE_W)
      ) u_q (
        .clk    (clk),
        .rst_n  (rst_int_n),
        .sample (conv_valid),
        .fault  (beyond[gi]),
        .need   (need),
        .trip   (trip[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  // order matters below: writes first, then read side effects,
  // then the shutdown clear, and last the new conversion result.
  // a later assignment wins, so a flag raised by a conversion in
  // the cycle of a status read survives the read; the price is
  // that such a read shows the flag as clear once more
  always_comb
  begin
    s_next        = s_reg;
    s_next.rvalid = reg_rd;

    // register writes; read-only addresses ignore the write
    if (reg_wr)
    begin
      unique case (reg_addr)
        temp_regs_pkg::ADDR_CONFIG: s_next.cfg  = reg_wdata[7:0];
        temp_regs_pkg::ADDR_CRIT:   s_next.crit = reg_wdata;
        temp_regs_pkg::ADDR_HYST:   s_next.hyst = reg_wdata[7:0];
        temp_regs_pkg::ADDR_HIGH:   s_next.high = reg_wdata;
        temp_regs_pkg::ADDR_LOW:    s_next.low  = reg_wdata;
        default:                    ;
      endcase
    end

    // register reads and their side effects
    if (reg_rd)
    begin
      unique case (reg_addr)
        temp_regs_pkg::ADDR_STATUS:
        begin
          s_next.rdata = {8'h00, s_reg.rdy, s_reg.flags, 4'h0};
          s_next.flags = 3'h0;
        end
        temp_regs_pkg::ADDR_CONFIG: s_next.rdata = {8'h00, s_reg.cfg};
        temp_regs_pkg::ADDR_TEMP:
        begin
          s_next.rdata = s_reg.temp;
          s_next.rdy   = 1'b1;
        end
        temp_regs_pkg::ADDR_IDENT:
          s_next.rdata = {8'h00, MAKER_CODE, REV_CODE};
        temp_regs_pkg::ADDR_CRIT:   s_next.rdata = s_reg.crit;
        temp_regs_pkg::ADDR_HYST:   s_next.rdata = {8'h00, s_reg.hyst};
        temp_regs_pkg::ADDR_HIGH:   s_next.rdata = s_reg.high;
        temp_regs_pkg::ADDR_LOW:    s_next.rdata = s_reg.low;
        default:                    s_next.rdata = 16'h0000;
      endcase
      // any read ends an interrupt-mode alarm
      if (!cmp_mode)
        s_next.alarm = 3'h0;
    end

    // shutdown drops interrupt-mode alarms, comparator keeps them
    if (shutdown && !cmp_mode)
      s_next.alarm = 3'h0;

    // a new result; sets come after the clears so an event
    // landing with a read or clear is never lost, except an interrupt-mode alarm in shutdown
    if (conv_valid)
    begin
      s_next.rdy = 1'b0;
      if (res16)
        s_next.temp = conv_data;
      else
        s_next.temp = {conv_data[15:3], beyond};
      for (int i = 0; i < 3; i++)
      begin
        if (released[i])
        begin
          s_next.excur[i] = 1'b0;
          s_next.flags[i] = 1'b0;
          if (cmp_mode)
            s_next.alarm[i] = 1'b0;
        end
        if (trip[i])
        begin
          s_next.flags[i] = 1'b1;
          s_next.excur[i] = 1'b1;
          // interrupt mode fires only on a fresh crossing
          if (cmp_mode || !s_reg.excur[i])
            s_next.alarm[i] = 1'b1;
          if (!cmp_mode && shutdown)
            s_next.alarm[i] = 1'b0;
        end
      end
    end

    // pins follow the alarm state with their polarity bits; the
    // next configuration is used so a polarity write moves the pin
    // in the same cycle as the register, with no stale level
    s_next.crit_pin  = pin_level(s_next.alarm[temp_regs_pkg::LIM_CRIT],
                                 s_next.cfg[temp_regs_pkg::CFG_CT_POL]);
    s_next.limit_pin = pin_level(s_next.alarm[temp_regs_pkg::LIM_HIGH]
                                 | s_next.alarm[temp_regs_pkg::LIM_LOW],
                                 s_next.cfg[temp_regs_pkg::CFG_INT_POL]);
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  // only constants in the reset branch; the fault queues share the
  // same released reset so they cannot count across a reset edge
  always_ff @(posedge clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      s_reg           <= '0;
      s_reg.temp      <= temp_regs_pkg::TEMP_RST;
      s_reg.cfg       <= temp_regs_pkg::CONFIG_RST;
      s_reg.crit      <= temp_regs_pkg::CRIT_RST;
      s_reg.hyst      <= temp_regs_pkg::HYST_RST;
      s_reg.high      <= temp_regs_pkg::HIGH_RST;
      s_reg.low       <= temp_regs_pkg::LOW_RST;
      s_reg.rdy       <= 1'b1;
      // default polarity is active low: inactive pin sits high
      s_reg.crit_pin  <= 1'b1;
      s_reg.limit_pin <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  // ------------------------------------------------------------
  // outputs straight from the state register
  // ------------------------------------------------------------
  // no logic after the flops: the pins cannot glitch while the
  // compare inputs settle, at the cost of one cycle of latency
  assign reg_rdata             = s_reg.rdata;
  assign reg_rvalid            = s_reg.rvalid;
  assign critical_alarm_output = s_reg.crit_pin;
  assign limit_alarm_output    = s_reg.limit_pin;

endmodule // temp_regs

`default_nettype wire

// ===== tb/temp_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none

module temp_regs_properties #(
  parameter logic [4:0] MAKER_CODE = 5'h0A,  // arbitrary value
  parameter logic [2:0] REV_CODE   = 3'h1    // arbitrary value
) (
  input wire logic        clk,                    // system clock
  input wire logic        rst_n,                  // reset, active low
  input wire logic        reg_wr,                 // write strobe
  input wire logic        reg_rd,                 // read strobe
  input wire logic [2:0]  reg_addr,               // register address
  input wire logic [15:0] reg_wdata,              // write data
  input wire logic        conv_valid,             // new result
  input wire logic [15:0] conv_data,              // result word
  input wire logic [15:0] reg_rdata,              // read data
  input wire logic        reg_rvalid,             // read data valid
  input wire logic        critical_alarm_output,  // critical pin
  input wire logic        limit_alarm_output      // limit pin
);
  // ----------------------------------------------------------
  // helper state
  // ----------------------------------------------------------
  logic res16_reg;  // shadow of the resolution bit

  // shadowed here because the checker cannot see the config register
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      res16_reg <= 1'b0;
    else if (reg_wr && reg_addr == 3'h1)
      res16_reg <= reg_wdata[7];

  // ----------------------------------------------------------
  // properties
  // ----------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // result arrives, no config write, then read of the result three cycles on
  sequence s_conv_then_rd;
    conv_valid && !reg_wr ##1 (!conv_valid && !reg_wr) [*2] ##1 reg_rd && reg_addr == 3'h2;
  endsequence
  sequence s_wr_then_rd;
    reg_wr ##1 !reg_wr ##1 reg_rd && reg_addr == $past(reg_addr, 2);
  endsequence

  property p_rvalid;
    reg_rd |=> reg_rvalid;
  endproperty
  property p_no_rvalid;
    !reg_rd |=> !reg_rvalid;
  endproperty
  property p_rdata_holds;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  property p_ident;
    reg_rd && reg_addr == 3'h3 |=> reg_rdata == {8'h00, MAKER_CODE, REV_CODE};
  endproperty
  property p_temp_value;
    s_conv_then_rd |=> reg_rdata[15:3] == $past(conv_data[15:3], 4);
  endproperty
  property p_temp_ext;
    s_conv_then_rd ##0 res16_reg |=> reg_rdata == $past(conv_data, 4);
  endproperty
  property p_rw_readback;
    s_wr_then_rd ##0 reg_addr inside {3'h4, 3'h6, 3'h7} |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  property p_hyst_readback;
    s_wr_then_rd ##0 reg_addr == 3'h5 |=> reg_rdata == {8'h00, $past(reg_wdata[7:0], 3)};
  endproperty
  property p_limit_cause;
    $changed(limit_alarm_output) |-> $past(conv_valid || reg_rd || reg_wr);
  endproperty
  property p_crit_cause;
    $changed(critical_alarm_output) |-> $past(conv_valid || reg_rd || reg_wr);
  endproperty

  a_rvalid: assert property (p_rvalid) else $error("read not answered");
  a_no_rvalid: assert property (p_no_rvalid) else $error("stray read valid");
  a_rdata_holds: assert property (p_rdata_holds) else $error("read data moved");
  a_ident: assert property (p_ident) else $error("identity word wrong");
  a_temp_value: assert property (p_temp_value) else $error("result wrong");
  a_temp_ext: assert property (p_temp_ext) else $error("wide result wrong");
  a_rw_readback: assert property (p_rw_readback) else $error("limit readback");
  a_hyst_readback: assert property (p_hyst_readback) else $error("hyst readback");
  a_limit_cause: assert property (p_limit_cause) else $error("limit pin moved");
  a_crit_cause: assert property (p_crit_cause) else $error("critical pin moved");
endmodule // temp_regs_properties

bind temp_regs temp_regs_properties #(
  .MAKER_CODE(MAKER_CODE),
  .REV_CODE  (REV_CODE)
) i_props (
  .clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .conv_valid(conv_valid), .conv_data(conv_data),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .critical_alarm_output(critical_alarm_output), .limit_alarm_output(limit_alarm_output)
);

`default_nettype wire

// ===== tb/conv_source.sv
`timescale 1ns/1ps
`default_nettype none

module conv_source (
  input  wire logic        clk,         // system clock
  input  wire logic        rst_n,       // reset, active low
  input  wire logic        go,          // send one result next cycle
  input  wire logic [15:0] value,       // result to send
  output logic             conv_valid,  // one-cycle result strobe
  output logic [15:0]      conv_data    // result word
);
  // data flips outside the strobe so a stale word never passes as fresh
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      conv_valid <= 1'b0;
      conv_data  <= 16'h5A5A;
    end
    else
    begin
      conv_valid <= go;
      conv_data  <= go ? value : ~conv_data;
    end
endmodule // conv_source

`default_nettype wire

// ===== tb/temp_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module temp_regs_tb_top;
  logic        clk, rst_n, reg_wr, reg_rd, go, conv_valid, reg_rvalid, crit_pin, limit_pin;
  logic [2:0]  reg_addr;
  logic [15:0] reg_wdata, value, conv_data, reg_rdata;
  int          fail_count, checks;
  // identity word of the default (arbitrary) maker and revision parameters
  localparam logic [15:0] ID_WORD = 16'h0051;
  localparam logic [2:0]  RA [6]  = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
  localparam logic [15:0] RV [6]  = '{16'h0000, ID_WORD, 16'h4980, 16'h0005, 16'h2000, 16'h0500};
  localparam logic [2:0]  WA [4]  = '{3'h4, 3'h5, 3'h6, 3'h7};
  localparam logic [15:0] WV [4]  = '{16'h8123, 16'h00FA, 16'hFE00, 16'h7FFF};

  temp_regs i_dut (
    .clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .conv_valid(conv_valid), .conv_data(conv_data),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .critical_alarm_output(crit_pin), .limit_alarm_output(limit_pin)
  );
  conv_source i_conv (
    .clk(clk), .rst_n(rst_n), .go(go), .value(value),
    .conv_valid(conv_valid), .conv_data(conv_data)
  );

  // ----------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, s, e);
    end
  endtask

  task automatic lim(input logic e);
    chk({15'h0000, limit_pin}, {15'h0000, e});
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // data is looked at after the edge that raises the valid flag has landed
  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk({15'h0000, reg_rvalid}, 16'h0001);
    chk(reg_rdata, e);
  endtask

  task automatic conv(input logic [15:0] d);
    @(posedge clk);
    go    <= 1'b1;
    value <= d;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic conclude();
    if (fail_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------
  // tests
  // ----------------------------------------------------------
  initial
  begin
    #200000;
    fail_count++;
    conclude();
  end

  initial
  begin
    {reg_wr, reg_rd, go, reg_addr, reg_wdata, value} = '0;
    rst_n      = 1'b0;
    fail_count = 0;
    checks     = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 6; i++)
      rd(RA[i], RV[i]);
    chk({14'h0000, crit_pin, limit_pin}, 16'h0003);
    // interrupt mode, active low pins, single fault
    conv(16'h2100);
    lim(1'b0);
    rd(3'h2, 16'h2102);
    lim(1'b1);
    conv(16'h4A00);
    chk({15'h0000, crit_pin}, 16'h0000);
    rd(3'h2, 16'h4A06);
    conv(16'h0400);
    lim(1'b0);
    rd(3'h2, 16'h0401);
    // comparator mode: clearing only past the hysteresis point
    wr(3'h1, 16'h0010);
    conv(16'h2100);
    lim(1'b0);
    conv(16'h1E00);
    lim(1'b0);
    rd(3'h5, 16'h0005);
    lim(1'b0);
    conv(16'h1D00);
    lim(1'b1);
    conv(16'hFF00);
    lim(1'b0);
    rd(3'h2, 16'hFF01);
    conv(16'h1000);
    lim(1'b1);
    // four consecutive faults needed
    wr(3'h1, 16'h0013);
    for (int i = 0; i < 4; i++)
    begin
      conv(16'h2100);
      lim(i < 3);
    end
    // wide result keeps its low bits
    wr(3'h1, 16'h0090);
    conv(16'h1237);
    rd(3'h2, 16'h1237);
    // active-high pins, comparator mode, then shutdown in both modes
    wr(3'h1, 16'h009C);
    conv(16'h4A00);
    chk({14'h0000, crit_pin, limit_pin}, 16'h0003);
    wr(3'h1, 16'h00FC);
    rd(3'h5, 16'h0005);
    chk({14'h0000, crit_pin, limit_pin}, 16'h0003);
    conv(16'h1000);
    chk({14'h0000, crit_pin, limit_pin}, 16'h0000);
    wr(3'h1, 16'h00EC);
    conv(16'h4A00);
    chk({14'h0000, crit_pin, limit_pin}, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      wr(WA[i], WV[i]);
      rd(WA[i], WV[i]);
    end
    // read-only places ignore writes
    wr(3'h2, 16'hAAAA);
    rd(3'h2, 16'h4A00);
    wr(3'h3, 16'h5555);
    rd(3'h3, ID_WORD);
    conclude();
  end
endmodule // temp_regs_tb_top

`default_nettype wire
